// file: include/serial_unit_pkg.sv
// Constants, types and behaviour notes for the universal serial unit.
// Notes on behaviour
// - 8-bit shift data register, directly accessed, no receive buffer.
// - Register MSB drives one of two pins, chosen by wire mode.
// - A transparent latch moves output changes to the non-sampling edge.
// - Serial input always comes from the serial input pin.
// - Readable, writable 4-bit counter; overflow can request an interrupt.
// - Internal clock: data register and counter step together from one source.
// - External clock, edge counting: the counter counts both edges, not bits.
// - Clock source: clock pin, timer compare match or software.
// - Two-wire mode: a detected start can request an interrupt.
// - Two-wire mode: clock line held low after start, and after overflow in the holding variant.
// - Three-wire mode follows SPI modes 0 and 1; no slave select.
// - Two joined units exchange registers in eight clock pulses.
// - Master clocks via the port output register or toggle strobe.
// - Polarity 0 samples rising, shifts falling; 1 is reversed.
// - Sixteen counted edges overflow the counter and set the flag.
// - The overflow interrupt can wake from idle sleep.
// - Status write with flag bit clears the flag and loads the counter.
// - External clock, strobe counting: each toggle strobe toggles and counts.
// - Alternating toggle and toggle-plus-strobe writes reach half system rate.
// - Two-wire start detection can wake from every sleep mode.
// - A data write beats a coinciding shift clock; no shift.
// - Start detector enabled only in two-wire mode.
package serial_unit_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int COUNT_W = 4;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 4'hF;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 4'h1;

    // ------------------------------------------------------------------
    // Synchroniser lanes and port direction bits
    // ------------------------------------------------------------------
    localparam int SYNC_W = 3;
    localparam int SYNC_SDI = 0;
    localparam int SYNC_SCK = 1;
    localparam int SYNC_START = 2;
    localparam int PORT_DIR_W = 3;
    localparam int DIR_DATA_OUT = 0;
    localparam int DIR_CLOCK = 1;
    localparam int DIR_SERIAL_IN = 2;

    // ------------------------------------------------------------------
    // Modes and grouped signals
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WIRE_NONE = 2'b00,
        WIRE_THREE = 2'b01,
        WIRE_TWO = 2'b10,
        WIRE_TWO_HOLD = 2'b11
    } wire_mode_type;

    typedef struct packed {
        wire_mode_type wire_mode;
        logic external_clock_select;
        logic edge_polarity_select;
        logic counter_strobe_select;
    } serial_config_type;

    typedef struct packed {
        logic write;
        logic clock_pin_toggle_strobe;
    } control_write_type;

    typedef struct packed {
        logic write;
        logic clear_overflow;
        logic clear_start;
        logic [COUNT_W-1:0] count;
    } status_write_type;

endpackage : serial_unit_pkg

// file: design/universal_serial_unit.sv
// Universal serial shift unit with its start condition detector.

// ----------------------------------------------------------------------
// Start condition detector, clocked by the falling data line
// ----------------------------------------------------------------------

// Runs without the system clock, so a start is caught while it is stopped.
module start_detector
(
    input wire logic sda_clk_in,
    input wire logic rst_b_in,
    input wire logic scl_level_in,
    input wire logic enable_in,
    output logic start_toggle_out
);
    import serial_unit_pkg::*;

    typedef struct packed {
        logic toggle;
    } detector_state_type;

    localparam detector_state_type DETECTOR_RESET = '{toggle: 1'b0};

    detector_state_type st_q;
    detector_state_type st_d;

    // A falling data line while the clock line is high marks a start.
    always_comb
    begin
        st_d = st_q;
        if (enable_in && scl_level_in)
        begin
            st_d.toggle = ~st_q.toggle;
        end
    end

    // Each start flips the toggle, an event that the system side resynchronises.
    always_ff @(negedge sda_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= DETECTOR_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign start_toggle_out = st_q.toggle;

endmodule : start_detector

// ----------------------------------------------------------------------
// Shift unit, system clock domain
// ----------------------------------------------------------------------

module universal_serial_unit
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic serial_in_pin_in,
    output logic serial_in_pin_out,
    output logic serial_in_pin_oe_b_out,
    output logic data_out_pin_out,
    output logic data_out_pin_oe_b_out,
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe_b_out,
    input wire logic [serial_unit_pkg::PORT_DIR_W-1:0] port_direction_reg_in,
    input wire serial_unit_pkg::serial_config_type serial_control_reg_in,
    input wire serial_unit_pkg::control_write_type control_write_in,
    input wire serial_unit_pkg::status_write_type serial_status_reg_write_in,
    input wire logic data_write_in,
    input wire logic [serial_unit_pkg::DATA_W-1:0] data_write_value_in,
    input wire logic clock_port_write_in,
    input wire logic clock_port_value_in,
    input wire logic timer_match_in,
    input wire logic overflow_irq_enable_in,
    input wire logic start_irq_enable_in,
    output logic [serial_unit_pkg::DATA_W-1:0] shift_data_reg_out,
    output logic [serial_unit_pkg::COUNT_W-1:0] counter_out,
    output logic counter_overflow_flag_out,
    output logic start_flag_out,
    output logic overflow_irq_out,
    output logic start_irq_out
);
    import serial_unit_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    typedef struct packed {
        logic [SYNC_W-1:0] in_meta;
        logic [SYNC_W-1:0] in_sync;
        logic sck_prev;
        logic start_seen;
        logic [DATA_W-1:0] data;
        logic out_latch;
        logic [COUNT_W-1:0] count;
        logic overflow_flag;
        logic start_flag;
        logic start_scl_low;
        logic clock_port;
    } unit_state_type;

    localparam unit_state_type UNIT_RESET = '{
        in_meta: '0,
        in_sync: '0,
        sck_prev: 1'b0,
        start_seen: 1'b0,
        data: DATA_RESET,
        out_latch: 1'b0,
        count: COUNT_RESET,
        overflow_flag: 1'b0,
        start_flag: 1'b0,
        start_scl_low: 1'b0,
        clock_port: 1'b0
    };

    unit_state_type st_q;
    unit_state_type st_d;

    logic start_toggle;
    logic two_wire;
    logic sck_level;
    logic sdi_level;
    logic sck_rise;
    logic sck_fall;
    logic sample_edge;
    logic soft_strobe;
    logic toggle_write;
    logic shift_event;
    logic count_event;
    logic overflow_event;
    logic start_event;
    logic latch_open;
    logic clear_overflow;
    logic clear_start;
    logic scl_hold;

    assign two_wire = (serial_control_reg_in.wire_mode == WIRE_TWO) ||
                      (serial_control_reg_in.wire_mode == WIRE_TWO_HOLD);

    // ------------------------------------------------------------------
    // Link side detector
    // ------------------------------------------------------------------

    // The quasi-static mode bit gates the detector unsynchronised.
    start_detector u_start_detector
    (
        .sda_clk_in(serial_in_pin_in),
        .rst_b_in(rst_b_in),
        .scl_level_in(shift_clock_pin_in),
        .enable_in(two_wire),
        .start_toggle_out(start_toggle)
    );

    // ------------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------------

    // Pin levels are read only after the second synchroniser stage.
    assign sck_level = st_q.in_sync[SYNC_SCK];
    assign sdi_level = st_q.in_sync[SYNC_SDI];
    assign sck_rise = sck_level && !st_q.sck_prev;
    assign sck_fall = !sck_level && st_q.sck_prev;
    assign sample_edge = serial_control_reg_in.edge_polarity_select ? sck_fall : sck_rise;
    assign toggle_write = control_write_in.write && control_write_in.clock_pin_toggle_strobe;
    assign soft_strobe = control_write_in.write && serial_control_reg_in.counter_strobe_select;

    // An internal source steps both the data register and the counter; the external clock shifts on the sampling edge.
    always_comb
    begin
        shift_event = 1'b0;
        count_event = 1'b0;
        if (serial_control_reg_in.external_clock_select)
        begin
            shift_event = sample_edge;
            if (serial_control_reg_in.counter_strobe_select)
            begin
                count_event = toggle_write;
            end
            else
            begin
                count_event = sck_rise || sck_fall;
            end
        end
        else if (serial_control_reg_in.edge_polarity_select)
        begin
            shift_event = timer_match_in;
            count_event = timer_match_in;
        end
        else
        begin
            // Strobe writes may arrive every cycle, which sets the top rate.
            shift_event = soft_strobe;
            count_event = soft_strobe;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    assign clear_overflow = serial_status_reg_write_in.write &&
                            serial_status_reg_write_in.clear_overflow;
    assign clear_start = serial_status_reg_write_in.write &&
                         serial_status_reg_write_in.clear_start;
    // A counter load suppresses a coinciding overflow.
    assign overflow_event = count_event && !serial_status_reg_write_in.write &&
                            (st_q.count == COUNT_MAX);
    assign start_event = (st_q.in_sync[SYNC_START] != st_q.start_seen) && two_wire;
    // The latch is open for an internal source, else off the sampling half.
    assign latch_open = !serial_control_reg_in.external_clock_select ||
                        (sck_level == serial_control_reg_in.edge_polarity_select);

    always_comb
    begin
        st_d = st_q;

        // Two flip-flops per pin lane; the first stage feeds only the second.
        st_d.in_meta = {start_toggle, shift_clock_pin_in, serial_in_pin_in};
        st_d.in_sync = st_q.in_meta;
        st_d.sck_prev = sck_level;
        st_d.start_seen = st_q.in_sync[SYNC_START];

        // A processor write beats a shift in the same cycle.
        if (data_write_in)
        begin
            st_d.data = data_write_value_in;
        end
        else if (shift_event)
        begin
            st_d.data = {st_q.data[DATA_W-2:0], sdi_level};
        end

        // The output follows the MSB only while the latch is open.
        if (latch_open)
        begin
            st_d.out_latch = st_q.data[DATA_W-1];
        end

        // Counter load by status write, else step on the selected source.
        if (serial_status_reg_write_in.write)
        begin
            st_d.count = serial_status_reg_write_in.count;
        end
        else if (count_event)
        begin
            // Adding one to the maximum wraps to zero with the flag set.
            st_d.count = st_q.count + COUNT_STEP;
        end

        // A start set wins over a software clear in the same cycle; a status write suppresses an overflow set.
        st_d.overflow_flag = (st_q.overflow_flag && !clear_overflow) || overflow_event;
        st_d.start_flag = (st_q.start_flag && !clear_start) || start_event;

        // The hold after start begins once the master pulls the clock low.
        st_d.start_scl_low = st_d.start_flag &&
                             (st_q.start_scl_low || (st_q.start_flag && !sck_level));

        // Port output register: direct write, then the toggle strobe.
        if (clock_port_write_in)
        begin
            st_d.clock_port = clock_port_value_in;
        end
        if (toggle_write)
        begin
            st_d.clock_port = ~st_d.clock_port;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // All state of the unit except the start detector toggle is registered here.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= UNIT_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------

    // The slave stretches the clock after a start, and after overflow in
    // the holding variant, until software clears the flag.
    assign scl_hold = two_wire && ((st_q.start_flag && st_q.start_scl_low) ||
                      ((serial_control_reg_in.wire_mode == WIRE_TWO_HOLD) &&
                       st_q.overflow_flag));

    // The MSB goes to the data output pin or the two-wire data line.
    always_comb
    begin
        data_out_pin_out = st_q.out_latch;
        data_out_pin_oe_b_out = 1'b1;
        serial_in_pin_out = 1'b0;
        serial_in_pin_oe_b_out = 1'b1;
        shift_clock_pin_out = st_q.clock_port;
        shift_clock_pin_oe_b_out = !port_direction_reg_in[DIR_CLOCK];
        case (serial_control_reg_in.wire_mode)
            WIRE_THREE:
            begin
                // No slave select: the direction bit alone enables the driver.
                data_out_pin_oe_b_out = !port_direction_reg_in[DIR_DATA_OUT];
            end
            WIRE_TWO, WIRE_TWO_HOLD:
            begin
                // Open drain: only a low level is ever driven.
                serial_in_pin_oe_b_out = !(port_direction_reg_in[DIR_SERIAL_IN] &&
                                           !st_q.out_latch);
                shift_clock_pin_out = 1'b0;
                shift_clock_pin_oe_b_out = !((port_direction_reg_in[DIR_CLOCK] &&
                                              !st_q.clock_port) || scl_hold);
            end
            default:
            begin
                data_out_pin_oe_b_out = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Status and requests
    // ------------------------------------------------------------------

    // Register contents go straight out; requests are flag and enable.
    assign shift_data_reg_out = st_q.data;
    assign counter_out = st_q.count;
    assign counter_overflow_flag_out = st_q.overflow_flag;
    assign start_flag_out = st_q.start_flag;
    assign overflow_irq_out = st_q.overflow_flag && overflow_irq_enable_in;
    assign start_irq_out = st_q.start_flag && start_irq_enable_in;

endmodule : universal_serial_unit

// file: testbench/serial_unit_sva.sv
// Port-level assertions for the universal serial unit.
module serial_unit_sva
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [serial_unit_pkg::PORT_DIR_W-1:0] port_direction_reg_in,
    input wire serial_unit_pkg::serial_config_type serial_control_reg_in,
    input wire serial_unit_pkg::control_write_type control_write_in,
    input wire serial_unit_pkg::status_write_type serial_status_reg_write_in,
    input wire logic data_write_in,
    input wire logic [serial_unit_pkg::DATA_W-1:0] data_write_value_in,
    input wire logic clock_port_write_in,
    input wire logic timer_match_in,
    input wire logic overflow_irq_enable_in,
    input wire logic data_out_pin_oe_b_out,
    input wire logic shift_clock_pin_out,
    input wire logic [serial_unit_pkg::DATA_W-1:0] shift_data_reg_out,
    input wire logic [serial_unit_pkg::COUNT_W-1:0] counter_out,
    input wire logic counter_overflow_flag_out,
    input wire logic start_flag_out,
    input wire logic overflow_irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import serial_unit_pkg::*;
    serial_config_type cfg;
    logic st_w;
    logic sw_sel;
    logic tm_sel;
    // ------------------------------------------------------------------
    // Clock source decode
    // ------------------------------------------------------------------
    // A coinciding status write beats a count, so it is excluded.
    assign cfg = serial_control_reg_in;
    assign st_w = serial_status_reg_write_in.write;
    assign sw_sel = !cfg.external_clock_select && !cfg.edge_polarity_select
                    && cfg.counter_strobe_select;
    assign tm_sel = !cfg.external_clock_select && cfg.edge_polarity_select;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence sw_step_s;
        sw_sel && control_write_in.write && !st_w;
    endsequence
    sequence tm_step_s;
        tm_sel && timer_match_in && !st_w;
    endsequence
    data_load_a : assert property (
        data_write_in |=> shift_data_reg_out == $past(data_write_value_in))
        else $error("data write not taken");
    count_load_a : assert property (
        st_w |=> counter_out == $past(serial_status_reg_write_in.count))
        else $error("status write did not load the counter");
    overflow_wrap_a : assert property (
        $rose(counter_overflow_flag_out) |-> counter_out == 4'h0)
        else $error("counter not zero at overflow");
    strobe_count_a : assert property (
        sw_step_s |=> counter_out == $past(counter_out) + 4'h1)
        else $error("strobe did not count");
    strobe_shift_a : assert property (
        sw_step_s ##0 !data_write_in
        |=> shift_data_reg_out[7:1] == $past(shift_data_reg_out[6:0]))
        else $error("strobe did not shift");
    timer_count_a : assert property (
        tm_step_s |=> counter_out == $past(counter_out) + 4'h1)
        else $error("timer match did not count");
    clock_toggle_a : assert property (
        control_write_in.write && control_write_in.clock_pin_toggle_strobe
        && !clock_port_write_in && !cfg.wire_mode[1]
        |=> cfg.wire_mode[1] || shift_clock_pin_out != $past(shift_clock_pin_out))
        else $error("toggle strobe did not flip the clock pin");
    no_start_a : assert property (
        !cfg.wire_mode[1] [*5] |-> !$rose(start_flag_out))
        else $error("start flagged outside two-wire mode");
    data_pin_a : assert property (
        data_out_pin_oe_b_out
        == !(cfg.wire_mode == WIRE_THREE && port_direction_reg_in[DIR_DATA_OUT]))
        else $error("data pin enable wrong");
    overflow_irq_a : assert property (
        overflow_irq_out == (counter_overflow_flag_out && overflow_irq_enable_in))
        else $error("overflow request wrong");
endmodule : serial_unit_sva

bind universal_serial_unit serial_unit_sva sva_chk (.clk_in, .rst_b_in, .port_direction_reg_in,
    .serial_control_reg_in, .control_write_in, .serial_status_reg_write_in, .data_write_in,
    .data_write_value_in, .clock_port_write_in, .timer_match_in, .overflow_irq_enable_in,
    .data_out_pin_oe_b_out, .shift_clock_pin_out, .shift_data_reg_out, .counter_out,
    .counter_overflow_flag_out, .start_flag_out, .overflow_irq_out);

// file: testbench/serial_peer_model.sv
// Remote three-wire peer in data mode 0: a link master or a slave.
module serial_peer_model
(
    input wire logic sck_in,
    input wire logic sdi_in,
    output logic sck_out,
    output logic sdo_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh_q = 8'h00;
    logic in_bit = 1'b0;
    logic active = 1'b0;
    logic run = 1'b0;
    logic lclk = 1'b0;
    initial sck_out = 1'b0;
    // Link clock of 48 ns, standing still outside frames.
    always #24 lclk = run & ~lclk;
    // Sample on the rising edge, present the next bit on the falling one.
    always @(posedge sck_in) in_bit <= sdi_in;
    always @(negedge sck_in) if (active) sh_q <= {sh_q[6:0], in_bit};
    // A released line shows the inverse of its last bit, never a held value.
    assign sdo_out = active ? sh_q[7] : ~sh_q[7];
    task automatic load(input logic [7:0] tx);
        sh_q = tx;
        active = 1'b1;
    endtask : load
    task automatic finish(output logic [7:0] rx);
        active = 1'b0;
        rx = sh_q;
    endtask : finish
    // Each level lasts two link periods, for the unit's synchroniser.
    task automatic master_xfer(input logic [7:0] tx, output logic [7:0] rx);
        load(tx);
        run = 1'b1;
        repeat (8)
        begin
            repeat (2) @(posedge lclk);
            sck_out = 1'b1;
            repeat (2) @(posedge lclk);
            sck_out = 1'b0;
        end
        repeat (2) @(posedge lclk);
        run = 1'b0;
        finish(rx);
    endtask : master_xfer
endmodule : serial_peer_model

// file: testbench/testbench.sv
// Self-checking bench for the universal serial unit and its remote peer.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import serial_unit_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [2:0] dir = 3'h0;
    serial_config_type cfg = '{WIRE_THREE, 1'b0, 1'b0, 1'b0};
    control_write_type cw = '0;
    status_write_type sw = '0;
    logic dw = 1'b0, cpw = 1'b0, cpv = 1'b0, tm = 1'b0, oen = 1'b1, tw = 1'b0;
    logic scl = 1'b1, sda = 1'b1;
    logic [7:0] dv = 8'h00;
    logic [7:0] rx;
    logic p_sck, p_sdo, data_line, shift_clock_pin_in, serial_in_pin_in;
    logic serial_in_pin_out, serial_in_pin_oe_b_out, data_out_pin_out, data_out_pin_oe_b_out;
    logic shift_clock_pin_out, shift_clock_pin_oe_b_out, counter_overflow_flag_out;
    logic start_flag_out, overflow_irq_out, start_irq_out;
    logic [7:0] shift_data_reg_out;
    logic [3:0] counter_out;
    int checks = 0;
    int bad_count = 0;
    // A pin follows the unit while enabled, else the far party; a released data line shows the inverse.
    assign shift_clock_pin_in = !shift_clock_pin_oe_b_out ? shift_clock_pin_out : (tw ? scl : p_sck);
    assign serial_in_pin_in = !serial_in_pin_oe_b_out ? serial_in_pin_out : (tw ? sda : p_sdo);
    assign data_line = !data_out_pin_oe_b_out ? data_out_pin_out : ~data_out_pin_out;
    universal_serial_unit DUT (.clk_in, .rst_b_in, .serial_in_pin_in, .serial_in_pin_out,
        .serial_in_pin_oe_b_out, .data_out_pin_out, .data_out_pin_oe_b_out, .shift_clock_pin_in,
        .shift_clock_pin_out, .shift_clock_pin_oe_b_out, .port_direction_reg_in(dir),
        .serial_control_reg_in(cfg), .control_write_in(cw), .serial_status_reg_write_in(sw),
        .data_write_in(dw), .data_write_value_in(dv), .clock_port_write_in(cpw),
        .clock_port_value_in(cpv), .timer_match_in(tm), .overflow_irq_enable_in(oen),
        .start_irq_enable_in(1'b1), .shift_data_reg_out, .counter_out,
        .counter_overflow_flag_out, .start_flag_out, .overflow_irq_out, .start_irq_out);
    serial_peer_model peer (.sck_in(shift_clock_pin_in), .sdi_in(data_line),
        .sck_out(p_sck), .sdo_out(p_sdo));
    initial forever #10 clk_in = ~clk_in;
    // Inputs change 2 ns after the rising edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : cyc
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic status(input logic clr_o, input logic clr_s, input logic [3:0] cnt);
        sw = '{1'b1, clr_o, clr_s, cnt};
        cyc(1);
        sw = '0;
    endtask : status
    task automatic load(input logic [7:0] v);
        dw = 1'b1;
        dv = v;
        cyc(1);
        dw = 1'b0;
    endtask : load
    task automatic t_collide();
        cfg = '{WIRE_THREE, 1'b0, 1'b0, 1'b1};
        dw = 1'b1;
        dv = 8'hA5;
        cw = '{1'b1, 1'b0};
        cyc(1);
        dw = 1'b0;
        cw = '0;
        chk(shift_data_reg_out === 8'hA5, "write lost to shift");
        cyc(1);
        cw = '{1'b1, 1'b0};
        cyc(1);
        cw = '0;
        chk(shift_data_reg_out[7:1] === 7'h25, "strobe shift wrong");
        $display("collision test done");
    endtask : t_collide
    task automatic t_timer();
        cfg = '{WIRE_THREE, 1'b0, 1'b1, 1'b0};
        status(1'b1, 1'b0, 4'hE);
        for (int i = 0; i < 2; i++)
        begin
            tm = 1'b1;
            cyc(1);
            tm = 1'b0;
            cyc(1);
            chk(counter_out === 4'hF + 4'(i), "timer count wrong");
        end
        chk(counter_overflow_flag_out === 1'b1 && overflow_irq_out === 1'b1, "no overflow");
        oen = 1'b0;
        cyc(1);
        chk(overflow_irq_out === 1'b0, "masked request seen");
        status(1'b1, 1'b0, 4'h0);
        chk(counter_overflow_flag_out === 1'b0, "flag not cleared");
        $display("timer test done");
    endtask : t_timer
    task automatic t_fast();
        cfg = '{WIRE_THREE, 1'b0, 1'b0, 1'b0};
        dir = 3'h3;
        // Toggle-only and toggle-plus-count writes alternate on every cycle.
        for (int i = 0; i < 16; i++)
        begin
            cw = '{1'b1, 1'b1};
            cfg.counter_strobe_select = i[0];
            cyc(1);
        end
        cw = '0;
        cyc(1);
        chk(counter_out === 4'h8 && counter_overflow_flag_out === 1'b0, "fast count");
        chk(shift_clock_pin_out === 1'b0, "clock pin level after 16 toggles");
        $display("fast master test done");
    endtask : t_fast
    task automatic t_master();
        cfg = '{WIRE_THREE, 1'b1, 1'b0, 1'b1};
        load(8'hA5);
        status(1'b1, 1'b0, 4'h0);
        peer.load(8'h3C);
        repeat (16)
        begin
            cw = '{1'b1, 1'b1};
            cyc(1);
            cw = '0;
            cyc(7);
        end
        peer.finish(rx);
        chk(shift_data_reg_out === 8'h3C && rx === 8'hA5, "master exchange");
        chk(counter_out === 4'h0 && counter_overflow_flag_out === 1'b1, "master end");
        $display("master test done");
    endtask : t_master
    task automatic t_slave();
        cfg = '{WIRE_THREE, 1'b1, 1'b0, 1'b0};
        dir = 3'h1;
        load(8'h5A);
        status(1'b1, 1'b0, 4'h0);
        peer.master_xfer(8'hC3, rx);
        cyc(6);
        chk(shift_data_reg_out === 8'hC3 && rx === 8'h5A, "slave exchange");
        chk(counter_out === 4'h0 && counter_overflow_flag_out === 1'b1, "edge count");
        $display("slave test done");
    endtask : t_slave
    task automatic t_start();
        tw = 1'b1;
        dir = 3'h2;
        cpw = 1'b1;
        cpv = 1'b1;
        cyc(1);
        cpw = 1'b0;
        sda = 1'b0;
        cyc(10);
        chk(start_flag_out === 1'b0, "start seen in three-wire mode");
        sda = 1'b1;
        cfg = '{WIRE_TWO, 1'b1, 1'b0, 1'b0};
        cyc(4);
        sda = 1'b0;
        cyc(10);
        chk(start_flag_out === 1'b1 && start_irq_out === 1'b1, "start missed");
        chk(shift_clock_pin_oe_b_out === 1'b1, "clock held too early");
        scl = 1'b0;
        cyc(6);
        chk(shift_clock_pin_oe_b_out === 1'b0, "clock not held");
        status(1'b0, 1'b1, 4'h0);
        cyc(3);
        chk(start_flag_out === 1'b0 && shift_clock_pin_oe_b_out === 1'b1, "hold stuck");
        $display("start test done");
    endtask : t_start
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    initial
    begin
        cyc(3);
        rst_b_in = 1'b1;
        chk(shift_data_reg_out === 8'h00 && counter_out === 4'h0, "reset values");
        t_collide();
        t_timer();
        t_fast();
        t_master();
        t_slave();
        t_start();
        results();
    end
    // Tests need under 2000 cycles; a hang is cut off at 5000.
    initial
    begin
        repeat (5000) @(posedge clk_in);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
endmodule : testbench
